// >>> rtl/ifetch_pkg.sv
// Constants, field positions and types shared by both ends of the fetch link.
package ifetch_pkg;
   // ==========================================================
   // Instruction fields
   localparam logic [1:0] TYPE_BLOCK_MOVE = 2'h0;
   localparam logic [1:0] TYPE_TRANSFER = 2'h2;
   localparam logic [1:0] TYPE_MEM_MOVE = 2'h3;
   localparam logic [2:0] OPC_INTERRUPT = 3'h3;
   localparam int BIT_INDIRECT = 29;
   localparam int BIT_TABLE = 28;
   localparam int BIT_PHASE_IN = 24;
   localparam int BIT_SRC_IO = 5;
   localparam int BIT_DST_IO = 4;
   localparam int BURST_LSB = 6;
   // ==========================================================
   // Host write selects
   localparam logic [1:0] SEL_POINTER = 2'h0;
   localparam logic [1:0] SEL_BASE = 2'h1;
   localparam logic [1:0] SEL_MODE = 2'h2;
   localparam logic [1:0] SEL_RAM = 2'h3;
   // ==========================================================
   // Address map and reset values
   localparam logic [19:0] RAM_PAGE = 20'hfffff;
   localparam int RAM_WORDS = 1024;
   localparam int RAM_AW = 10;
   localparam int HOST_WORDS = 256;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam logic [23:0] BURST_MIN_BYTES = 24'h000008;
   localparam logic [31:0] POINTER_RESET = 32'h0000_0000;
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_WAIT = 3'b010,
      ST_GRANT = 3'b011,
      ST_LOAD = 3'b100,
      ST_BEAT = 3'b101,
      ST_HALT = 3'b110
   } state_t;
   typedef enum logic [2:0] {
      STEP_CMD = 3'b000,
      STEP_ADDR = 3'b001,
      STEP_SHADOW = 3'b010,
      STEP_POINTER = 3'b011,
      STEP_COUNT = 3'b100,
      STEP_DATA_ADDR = 3'b101
   } step_t;
endpackage : ifetch_pkg

// >>> rtl/fetch_link_if.sv
// Link between the instruction processor and the host CPU with its memory.
`timescale 1ns/10ps
`default_nettype none
interface fetch_link_if;
   logic wr_en;
   logic [1:0] wr_sel;
   logic [31:0] wr_data;
   logic [9:0] ram_addr;
   logic irq;
   logic bus_req;
   logic bus_gnt;
   logic bus_valid;
   logic bus_ready;
   logic [31:0] bus_addr;
   logic bus_io;
   logic bus_write;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   modport device (
      input wr_en, wr_sel, wr_data, ram_addr, bus_gnt, bus_ready, bus_rdata,
      output irq, bus_req, bus_valid, bus_addr, bus_io, bus_write, bus_wdata
   );
   modport host (
      output wr_en, wr_sel, wr_data, ram_addr, bus_gnt, bus_ready, bus_rdata,
      input irq, bus_req, bus_valid, bus_addr, bus_io, bus_write, bus_wdata
   );
endinterface : fetch_link_if
`default_nettype wire

// >>> rtl/ifetch_device.sv
// Instruction fetch, block-move address resolution and burst engine.
//
// Function
// RULE1: Host writes start address on four-byte boundary.
// RULE2: Instructions are eight or twelve bytes long.
// RULE3: Run until interrupt or error, then halt.
// RULE4: Pointer write starts fetching; host restarts there.
// RULE5: Words load command, second and shadow registers.
// RULE6: Indirect moves add one or two fetches.
// RULE7: Top byte decodes; count and address follow.
// RULE8: Wait for FIFO room or data first.
// RULE9: One burst, update count and address, release.
// RULE10: Count zero releases bus, fetches next instruction.
// RULE11: Mode bits pick I/O or memory space.
// RULE12: Bits 31-30 identify a block move.
// RULE13: Direct mode loads second word as address.
// RULE14: Indirect mode fetches address through pointer.
// RULE15: Table mode adds signed offset to base.
// RULE16: Table offset ignores bits 31-24.
// RULE17: Never set indirect and table together.
// RULE18: Host loads aligned structure base first.
// RULE19: Table entry is count then address.
// RULE20: No indirect fetch during memory-to-memory moves.
// RULE21: Address selects internal RAM or system memory.
`timescale 1ns/10ps
`default_nettype none
module ifetch_device (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   fetch_link_if.device link,
   input wire logic [7:0] fifo_space,
   input wire logic [7:0] fifo_level,
   input wire logic [31:0] fifo_rdata,
   output logic fifo_push,
   output logic [31:0] fifo_wdata,
   output logic fifo_pop,
   output logic halted,
   output logic illegal
);
   import ifetch_pkg::*;

   // ==========================================================
   // State
   state_t state;
   step_t step;
   logic [31:0] pointer;
   logic [31:0] read_addr;
   logic [7:0] command_byte_reg;
   logic [23:0] byte_count_reg;
   logic [31:0] second_word_reg;
   logic [31:0] shadow_word_reg;
   logic [31:0] next_data_address_reg;
   logic [31:0] structure_base_reg;
   logic [7:0] dma_mode_reg;
   logic [4:0] beats;
   logic [31:0] ram [0:RAM_WORDS-1];

   // ==========================================================
   // Decode helpers
   logic internal;
   logic word_ok;
   logic [31:0] word;
   logic receive;
   logic [23:0] burst_bytes;
   logic [23:0] chunk;
   logic fifo_ready;
   logic pointer_write;
   logic [31:0] table_addr;

   assign pointer_write = link.wr_en && (link.wr_sel == SEL_POINTER);
   assign internal = (read_addr[31:12] == RAM_PAGE); // [RULE21]
   assign word = internal ? ram[read_addr[11:2]] : link.bus_rdata;
   assign word_ok = internal || (link.bus_valid && link.bus_ready);
   assign receive = command_byte_reg[BIT_PHASE_IN - 24];
   assign burst_bytes = BURST_MIN_BYTES << dma_mode_reg[BURST_LSB+1:BURST_LSB];
   assign chunk = (byte_count_reg < burst_bytes) ? byte_count_reg : burst_bytes;
   // Receiving needs collected data, sending needs free room. [RULE8]
   assign fifo_ready = receive ? ({16'h0000, fifo_level} >= chunk)
                               : ({16'h0000, fifo_space} >= chunk);
   // Top byte is dropped so sign-extended offsets work either way. [RULE15] [RULE16]
   assign table_addr = structure_base_reg + {{8{word[23]}}, word[23:0]};

   // ==========================================================
   // Host-written configuration
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         structure_base_reg <= BASE_RESET;
         dma_mode_reg <= MODE_RESET;
      end
      else if (clk_en && link.wr_en)
      begin
         if (link.wr_sel == SEL_BASE)
            structure_base_reg <= link.wr_data;
         else if (link.wr_sel == SEL_MODE)
            dma_mode_reg <= link.wr_data[7:0];
      end
   end

   // Internal RAM has no reset; the host loads it before use.
   always_ff @(posedge sys_clk)
   begin
      if (clk_en && link.wr_en && (link.wr_sel == SEL_RAM))
         ram[link.ram_addr] <= link.wr_data;
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= ST_IDLE;
         step <= STEP_CMD;
         pointer <= POINTER_RESET;
         read_addr <= POINTER_RESET;
         command_byte_reg <= 8'h00;
         byte_count_reg <= 24'h000000;
         second_word_reg <= 32'h0000_0000;
         shadow_word_reg <= 32'h0000_0000;
         next_data_address_reg <= 32'h0000_0000;
         beats <= 5'h00;
         halted <= 1'b0;
         illegal <= 1'b0;
         fifo_push <= 1'b0;
         fifo_pop <= 1'b0;
         fifo_wdata <= 32'h0000_0000;
         link.irq <= 1'b0;
         link.bus_req <= 1'b0;
         link.bus_valid <= 1'b0;
         link.bus_addr <= 32'h0000_0000;
         link.bus_io <= 1'b0;
         link.bus_write <= 1'b0;
         link.bus_wdata <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         fifo_push <= 1'b0;
         fifo_pop <= 1'b0;
         if (pointer_write)
         begin
            // A pointer write restarts fetching at once, from any state. [RULE4]
            pointer <= link.wr_data;
            read_addr <= link.wr_data;
            step <= STEP_CMD;
            state <= ST_READ;
            halted <= 1'b0;
            illegal <= 1'b0;
            link.irq <= 1'b0;
            link.bus_req <= 1'b0;
            link.bus_valid <= 1'b0;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  link.bus_req <= 1'b0;
               end
               ST_READ:
               begin
                  link.bus_req <= !internal; // [RULE21]
                  link.bus_write <= 1'b0;
                  link.bus_io <= 1'b0;
                  // A grant left over from a request just dropped is not trusted.
                  if (!internal && link.bus_req && !link.bus_valid && link.bus_gnt)
                  begin
                     link.bus_valid <= 1'b1;
                     link.bus_addr <= read_addr;
                  end
                  if (word_ok)
                  begin
                     link.bus_valid <= 1'b0;
                     case (step)
                        STEP_CMD:
                        begin
                           // First word: command byte and count. [RULE5] [RULE7]
                           command_byte_reg <= word[31:24];
                           byte_count_reg <= word[23:0];
                           pointer <= pointer + WORD_BYTES;
                           read_addr <= pointer + WORD_BYTES;
                           step <= STEP_ADDR;
                        end
                        STEP_ADDR:
                        begin
                           second_word_reg <= word; // [RULE5] [RULE7]
                           pointer <= pointer + WORD_BYTES;
                           read_addr <= pointer + WORD_BYTES;
                           step <= STEP_CMD;
                           if (command_byte_reg[7:6] == TYPE_BLOCK_MOVE) // [RULE12]
                           begin
                              link.bus_req <= 1'b0;
                              // The table bit wins if both are set. [RULE17]
                              if (command_byte_reg[BIT_TABLE - 24])
                              begin
                                 read_addr <= table_addr; // [RULE6] [RULE15]
                                 step <= STEP_COUNT;
                              end
                              else if (command_byte_reg[BIT_INDIRECT - 24])
                              begin
                                 read_addr <= word; // [RULE6] [RULE14]
                                 step <= STEP_POINTER;
                              end
                              else
                              begin
                                 next_data_address_reg <= word; // [RULE13]
                                 state <= ST_WAIT;
                              end
                           end
                           else if (command_byte_reg[7:6] == TYPE_MEM_MOVE)
                              step <= STEP_SHADOW; // [RULE2]
                           else if ((command_byte_reg[7:6] == TYPE_TRANSFER) &&
                                    (command_byte_reg[5:3] == OPC_INTERRUPT))
                              state <= ST_HALT; // [RULE3]
                        end
                        STEP_SHADOW:
                        begin
                           // The third word never triggers an indirect fetch. [RULE5] [RULE20]
                           shadow_word_reg <= word;
                           pointer <= pointer + WORD_BYTES;
                           read_addr <= pointer + WORD_BYTES;
                           step <= STEP_CMD;
                        end
                        STEP_POINTER:
                        begin
                           next_data_address_reg <= word; // [RULE14]
                           link.bus_req <= 1'b0;
                           state <= ST_WAIT;
                        end
                        STEP_COUNT:
                        begin
                           byte_count_reg <= word[23:0]; // [RULE15] [RULE19]
                           read_addr <= read_addr + WORD_BYTES;
                           step <= STEP_DATA_ADDR;
                        end
                        default:
                        begin
                           next_data_address_reg <= word; // [RULE19]
                           link.bus_req <= 1'b0;
                           state <= ST_WAIT;
                        end
                     endcase
                  end
               end
               ST_WAIT:
               begin
                  link.bus_req <= 1'b0;
                  if (byte_count_reg == 24'h000000)
                  begin
                     // A zero count is an illegal move and stops execution.
                     illegal <= 1'b1;
                     state <= ST_HALT; // [RULE3]
                  end
                  else if (fifo_ready)
                  begin
                     link.bus_req <= 1'b1; // [RULE8]
                     link.bus_addr <= next_data_address_reg;
                     link.bus_write <= receive;
                     // Source space when sending, destination when receiving. [RULE11]
                     link.bus_io <= receive ? dma_mode_reg[BIT_DST_IO]
                                            : dma_mode_reg[BIT_SRC_IO];
                     beats <= 5'(({8'h00, chunk} + 32'd3) >> 2);
                     state <= ST_GRANT;
                  end
               end
               ST_GRANT:
               begin
                  if (link.bus_gnt)
                  begin
                     if (receive)
                        state <= ST_LOAD;
                     else
                     begin
                        link.bus_valid <= 1'b1;
                        state <= ST_BEAT;
                     end
                  end
               end
               ST_LOAD:
               begin
                  link.bus_wdata <= fifo_rdata;
                  fifo_pop <= 1'b1;
                  link.bus_valid <= 1'b1;
                  state <= ST_BEAT;
               end
               ST_BEAT:
               begin
                  if (link.bus_ready)
                  begin
                     link.bus_valid <= 1'b0;
                     link.bus_addr <= link.bus_addr + WORD_BYTES;
                     beats <= beats - 5'h01;
                     if (!receive)
                     begin
                        fifo_wdata <= link.bus_rdata;
                        fifo_push <= 1'b1;
                     end
                     if (beats == 5'h01)
                     begin
                        // Burst done: account for it and give the bus back. [RULE9]
                        byte_count_reg <= byte_count_reg - chunk;
                        next_data_address_reg <= next_data_address_reg + {8'h00, chunk};
                        link.bus_req <= 1'b0;
                        if (byte_count_reg == chunk)
                        begin
                           read_addr <= pointer; // [RULE10]
                           step <= STEP_CMD;
                           state <= ST_READ;
                        end
                        else
                           state <= ST_WAIT;
                     end
                     else
                        state <= ST_GRANT;
                  end
               end
               default:
               begin
                  // Halted until the host writes a new pointer. [RULE3] [RULE4]
                  halted <= 1'b1;
                  link.irq <= 1'b1;
                  link.bus_req <= 1'b0;
                  link.bus_valid <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule : ifetch_device
`default_nettype wire

// >>> rtl/ifetch_host.sv
// Host end: CPU write port, system memory and bus arbiter for the processor.
`timescale 1ns/10ps
`default_nettype none
module ifetch_host (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   fetch_link_if.host link,
   input wire logic cpu_write,
   input wire logic [1:0] cpu_sel,
   input wire logic [31:0] cpu_data,
   input wire logic [9:0] cpu_addr,
   input wire logic cpu_mem_write,
   output logic irq_seen
);
   import ifetch_pkg::*;

   // ==========================================================
   // System memory
   logic [31:0] mem [0:HOST_WORDS-1];
   logic [7:0] index;

   // I/O and memory space share one array in this end.
   assign index = link.bus_addr[9:2];

   always_ff @(posedge sys_clk)
   begin
      if (clk_en)
      begin
         if (cpu_mem_write)
            mem[cpu_addr[7:0]] <= cpu_data;
         else if (link.bus_valid && link.bus_gnt && !link.bus_ready && link.bus_write)
            mem[index] <= link.bus_wdata;
      end
   end

   // ==========================================================
   // CPU writes and bus answers
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         link.wr_en <= 1'b0;
         link.wr_sel <= SEL_POINTER;
         link.wr_data <= 32'h0000_0000;
         link.ram_addr <= 10'h000;
         link.bus_gnt <= 1'b0;
         link.bus_ready <= 1'b0;
         link.bus_rdata <= 32'h0000_0000;
         irq_seen <= 1'b0;
      end
      else if (clk_en)
      begin
         link.wr_en <= cpu_write;
         link.wr_sel <= cpu_sel;
         link.ram_addr <= cpu_addr;
         // Pointer and base are forced to word alignment. [RULE1] [RULE18]
         if ((cpu_sel == SEL_POINTER) || (cpu_sel == SEL_BASE))
            link.wr_data <= {cpu_data[31:2], 2'b00};
         else
            link.wr_data <= cpu_data;
         irq_seen <= link.irq;
         link.bus_gnt <= link.bus_req;
         link.bus_ready <= 1'b0;
         if (link.bus_valid && link.bus_gnt && !link.bus_ready)
         begin
            link.bus_ready <= 1'b1;
            link.bus_rdata <= mem[index];
         end
      end
   end
endmodule : ifetch_host
`default_nettype wire

// >>> verification/fetch_link_monitor.sv
// Concurrent checks on the fetch link between the processor and its host.
`timescale 1ns/10ps
`default_nettype none
module fetch_link_monitor
   import ifetch_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [1:0] wr_sel,
   input wire logic [31:0] wr_data,
   input wire logic irq,
   input wire logic bus_req,
   input wire logic bus_gnt,
   input wire logic bus_valid,
   input wire logic bus_ready,
   input wire logic [31:0] bus_addr,
   input wire logic bus_io,
   input wire logic bus_write,
   input wire logic [31:0] bus_wdata
);
   // ==========================================================
   // Shadow copies of host writes
   logic ptr_wr;
   logic ram_hit;
   logic [31:0] ptr_q;
   logic [7:0] mode_q;
   assign ptr_wr = wr_en && wr_sel == SEL_POINTER;
   assign ram_hit = wr_data[31:12] == RAM_PAGE;
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n) ptr_q <= POINTER_RESET;
      else if (ptr_wr) ptr_q <= {wr_data[31:2], 2'h0};
   always_ff @(posedge sys_clk or negedge reset_n)
      if (!reset_n) mode_q <= MODE_RESET;
      else if (wr_en && wr_sel == SEL_MODE) mode_q <= wr_data[7:0];
   // ==========================================================
   // Assertions
   // The fixed delays assume the host grants one cycle after a request.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   ptr_start_a: assert property (ptr_wr && !ram_hit |-> ##2 bus_req)
      else $error("No bus request after pointer write.");
   ptr_addr_a: assert property (ptr_wr && !ram_hit |-> ##4 bus_valid && bus_addr == ptr_q)
      else $error("First fetch not at written pointer.");
   word_aligned_a: assert property (bus_valid && !bus_write |-> bus_addr[1:0] == 2'h0)
      else $error("Fetch address not on a word boundary.");
   ram_quiet_a: assert property (ptr_wr && ram_hit |=> !bus_req [*2])
      else $error("Internal RAM fetch used the bus.");
   beat_hold_a: assert property (bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr)
      && $stable(bus_wdata))
      else $error("Bus request changed before ready.");
   bus_owner_a: assert property (bus_valid |-> bus_req && bus_gnt)
      else $error("Bus beat without grant.");
   halt_quiet_a: assert property (irq && $past(irq) |-> !bus_req && !bus_valid)
      else $error("Bus activity while halted.");
   irq_hold_a: assert property (irq && !ptr_wr |=> irq)
      else $error("Interrupt dropped without restart.");
   irq_clear_a: assert property (irq && ptr_wr |=> !irq)
      else $error("Interrupt kept after restart.");
   dst_space_a: assert property (bus_valid && bus_write |-> bus_io == mode_q[BIT_DST_IO])
      else $error("Receive space select wrong.");
   cover property (bus_valid && bus_ready && bus_write);
   cover property ($rose(irq));
   cover property (ptr_wr && ram_hit);
endmodule : fetch_link_monitor
`default_nettype wire

// >>> verification/tb_instr_fetch_block_move.sv
// Self-checking bench joining the processor and host ends of the fetch link.
`timescale 1ns/10ps
`default_nettype none
module tb_instr_fetch_block_move;
   import ifetch_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cpu_write = 1'b0;
   logic cpu_mem_write = 1'b0;
   logic [1:0] cpu_sel = 2'h0;
   logic [31:0] cpu_data = 32'h0;
   logic [9:0] cpu_addr = 10'h0;
   logic [7:0] fifo_space = 8'h04;
   logic [7:0] fifo_level = 8'h00;
   logic [15:0] rx_idx = 16'h0;
   logic [31:0] fifo_rdata;
   logic [31:0] fifo_wdata;
   logic fifo_push, fifo_pop, halted, illegal, irq_seen;
   int fails = 0;
   int comparisons = 0;
   int io_rd = 0;
   int mem_rd = 0;
   int m0;
   logic [31:0] push_q[$];
   logic [63:0] wr_q[$];
   // Program words, indirect pointer, table entry and payload; index is the word address.
   logic [39:0] img[19] = '{{8'h00, 32'h00000010}, {8'h01, 32'h00000040},
      {8'h02, 32'h20000008}, {8'h03, 32'h00000080}, {8'h04, 32'h11000000},
      {8'h05, 32'h12fffff8}, {8'h06, 32'h98000000}, {8'h07, 32'h0}, {8'h08, 32'h0},
      {8'h09, 32'h00000040}, {8'h10, 32'h11110000}, {8'h11, 32'h11110001},
      {8'h12, 32'h11110002}, {8'h13, 32'h11110003}, {8'h18, 32'h22220000},
      {8'h19, 32'h22220001}, {8'h20, 32'h00000060}, {8'h28, 32'h00000008},
      {8'h29, 32'h00000070}};
   logic [31:0] exp_push[6] = '{32'h11110000, 32'h11110001, 32'h11110002, 32'h11110003,
      32'h22220000, 32'h22220001};
   assign fifo_rdata = {16'hbeef, rx_idx};
   always #10 sys_clk = ~sys_clk;
   fetch_link_if link();
   ifetch_device ifetch_device_i(.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
      .link(link), .fifo_space(fifo_space), .fifo_level(fifo_level),
      .fifo_rdata(fifo_rdata), .fifo_push(fifo_push), .fifo_wdata(fifo_wdata),
      .fifo_pop(fifo_pop), .halted(halted), .illegal(illegal));
   ifetch_host ifetch_host_i(.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
      .link(link), .cpu_write(cpu_write), .cpu_sel(cpu_sel), .cpu_data(cpu_data),
      .cpu_addr(cpu_addr), .cpu_mem_write(cpu_mem_write), .irq_seen(irq_seen));
   fetch_link_monitor fetch_link_monitor_i(.sys_clk(sys_clk), .reset_n(reset_n),
      .wr_en(link.wr_en), .wr_sel(link.wr_sel), .wr_data(link.wr_data), .irq(link.irq),
      .bus_req(link.bus_req), .bus_gnt(link.bus_gnt), .bus_valid(link.bus_valid),
      .bus_ready(link.bus_ready), .bus_addr(link.bus_addr), .bus_io(link.bus_io),
      .bus_write(link.bus_write), .bus_wdata(link.bus_wdata));
   // ==========================================================
   // Observers of the FIFO side and of finished bus beats
   always @(posedge sys_clk)
   begin
      if (fifo_push === 1'b1) push_q.push_back(fifo_wdata);
      if (fifo_pop === 1'b1) rx_idx <= rx_idx + 16'h1;
      if (link.bus_valid === 1'b1 && link.bus_ready === 1'b1)
      begin
         if (link.bus_write) wr_q.push_back({link.bus_addr, link.bus_wdata});
         else if (link.bus_io) io_rd++;
         else mem_rd++;
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("Mismatches %0d, comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   // One host write: to host memory when mem is set, else to the device select.
   task automatic put(input logic mem, input logic [1:0] sel, input logic [9:0] addr,
      input logic [31:0] data);
      @(posedge sys_clk);
      #1;
      cpu_write = !mem;
      cpu_mem_write = mem;
      cpu_sel = sel;
      cpu_addr = addr;
      cpu_data = data;
      @(posedge sys_clk);
      #1;
      cpu_write = 1'b0;
      cpu_mem_write = 1'b0;
   endtask : put
   task automatic run_to_halt;
      int n;
      n = 0;
      repeat (3) @(posedge sys_clk);
      #1;
      while (halted !== 1'b1 && n < 3000)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      // Let the delayed interrupt copy settle before anyone looks at it.
      repeat (2) @(posedge sys_clk);
      #1;
      if (halted !== 1'b1)
      begin
         fails++;
         $display("[ERR] %0t device never halted", $time);
         finish_test();
      end
   endtask : run_to_halt
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (8) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      chk(link.bus_req, 1'b0, "request before start");
      chk(halted, 1'b0, "halted after reset");
      foreach (img[i]) put(1'b1, SEL_POINTER, {2'h0, img[i][39:32]}, img[i][31:0]);
      put(1'b0, SEL_BASE, 10'h0, 32'h000000a8);
      put(1'b0, SEL_MODE, 10'h0, 32'h00000000);
      put(1'b0, SEL_POINTER, 10'h0, 32'h00000000);
      // The FIFO lacks room for one burst, so only the two instruction words may move.
      repeat (40) @(posedge sys_clk);
      #1;
      chk(push_q.size(), 0, "burst without FIFO room");
      chk(mem_rd, 2, "instruction word reads");
      fifo_space = 8'hff;
      fifo_level = 8'hff;
      run_to_halt();
      chk(push_q.size(), 6, "sent words");
      for (int i = 0; i < 6; i++) chk(push_q[i], exp_push[i], "sent data");
      chk(wr_q.size(), 2, "received beats");
      chk(wr_q[0], 64'h00000070_beef0000, "table receive 0");
      chk(wr_q[1], 64'h00000074_beef0001, "table receive 1");
      chk(illegal, 1'b0, "illegal on good program");
      chk(irq_seen, 1'b1, "interrupt to host");
      put(1'b0, SEL_POINTER, 10'h0, 32'h00000020);
      run_to_halt();
      chk(illegal, 1'b1, "zero count not flagged");
      chk(push_q.size(), 6, "zero count moved data");
      put(1'b0, SEL_RAM, 10'h0, 32'h00000008);
      put(1'b0, SEL_RAM, 10'h1, 32'h00000048);
      put(1'b0, SEL_RAM, 10'h2, 32'h98000000);
      put(1'b0, SEL_RAM, 10'h3, 32'h00000000);
      put(1'b0, SEL_MODE, 10'h0, 32'h00000020);
      m0 = mem_rd;
      put(1'b0, SEL_POINTER, 10'h0, 32'hfffff000);
      run_to_halt();
      chk(mem_rd, m0, "memory reads for RAM program");
      chk(io_rd, 2, "source beats in I/O space");
      chk(push_q.size(), 8, "RAM program sent words");
      chk(push_q[6], 32'h11110002, "RAM program data 0");
      chk(push_q[7], 32'h11110003, "RAM program data 1");
      finish_test();
   end
endmodule : tb_instr_fetch_block_move
`default_nettype wire
